/* common/txirq_pkg.sv */
// txirq_pkg: register map, field positions and reset values for the
// transmit event status block. assumes an 8-bit register port.
package txirq_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] ADDR_CTRL = 6'h03;
    localparam logic [5:0] ADDR_TX_IRQ_EN = 6'h0D;
    localparam logic [5:0] ADDR_TX_STATUS = 6'h0E;
    localparam logic [5:0] ADDR_TX_HOLD = 6'h0F;
    localparam int CTRL_TX_EN_BIT = 7;
    localparam int CTRL_RX_EN_BIT = 6;
    localparam int ST_EMPTY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_OVFL = 2;
    localparam int ST_UNFL = 3;
    localparam int NUM_FLAGS = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [7:0] HOLD_RESET = 8'h00;
endpackage : txirq_pkg

/* core/txirq_flag.sv */
// txirq_flag: one sticky status flag, set wins over clear.
// assumes set and clear are single-cycle strobes on i_clk.
`timescale 1ns/1ps
module txirq_flag (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_set,
    input wire logic i_clr,
    input wire logic i_force_off,
    // state
    output logic o_flag
);
    logic flag_ff;
    logic nxt_flag;

    // set wins over clear; forced low outside transmit mode
    assign nxt_flag = i_force_off ? 1'b0 : (i_set | (flag_ff & ~i_clr));
    assign o_flag = flag_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_ff <= 1'b0;
        end else if (i_ce) begin
            flag_ff <= nxt_flag;
        end
    end
endmodule : txirq_flag

/* core/txirq_status.sv */
// txirq_status: transmit event status, enables and holding register.
// assumes a synchronous register port from the serial interface logic
// and load/sample strobes from the transmit shifter on i_clk.
`timescale 1ns/1ps
// Behaviour
// - shifter wants a bit while holding register is empty sets underflow.
// - underflow only after one bit shifted since transmit start.
// - reading status clears the underflow, overflow and done flags returned.
// - writing holding register while still full sets overflow.
// - byte finished with nothing waiting sets done.
// - done only after one bit has been transmitted.
// - holding byte moved into shifter sets empty.
// - writing holding register clears empty; host writes only when empty.
// - flags set and readable regardless of interrupt enables.
// - transmit disabled forces status to zero; enables in control 7:6.
// - status bits 7:4 reserved zero, register read-only.
// - interrupt enable register mirrors status layout, 1 enables.
module txirq_status (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [txirq_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [txirq_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [txirq_pkg::DATA_W-1:0] o_reg_rdata,
    // transmit shifter strobes
    input wire logic i_shift_load,
    input wire logic i_shift_sample,
    input wire logic i_shift_byte_end,
    // outputs to shifter and host
    output logic [txirq_pkg::DATA_W-1:0] o_tx_data,
    output logic o_tx_enable,
    output logic o_rx_enable,
    output logic o_irq
);
    import txirq_pkg::*;

    logic rst_sync1_ff;
    logic rst_sync2_ff;
    logic [7:0] ctrl_ff;
    logic [3:0] irq_en_ff;
    logic [7:0] hold_ff;
    logic hold_full_ff;
    logic shifted_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic [3:0] flags;
    logic [3:0] set_vec;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end

    // decode
    wire wr_ctrl = i_reg_wr & (i_reg_addr == ADDR_CTRL);
    wire wr_en = i_reg_wr & (i_reg_addr == ADDR_TX_IRQ_EN);
    wire wr_hold = i_reg_wr & (i_reg_addr == ADDR_TX_HOLD);
    wire rd_stat = i_reg_rd & (i_reg_addr == ADDR_TX_STATUS);
    wire tx_en = ctrl_ff[CTRL_TX_EN_BIT];
    wire take = i_shift_load & hold_full_ff & tx_en;

    // event set terms
    assign set_vec[ST_UNFL] = tx_en & i_shift_sample & ~hold_full_ff
                            & shifted_ff;
    assign set_vec[ST_OVFL] = tx_en & wr_hold & hold_full_ff
                            & ~take;
    assign set_vec[ST_DONE] = tx_en & i_shift_byte_end & ~hold_full_ff
                            & shifted_ff;
    assign set_vec[ST_EMPTY] = take;

    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
            // empty clears on data write, others on status read
            wire clr = (g == ST_EMPTY) ? wr_hold : rd_stat;
            txirq_flag u_flag (
                .i_clk(i_clk),
                .i_rst_n(rst_sync2_ff),
                .i_ce(i_ce),
                .i_set(set_vec[g]),
                .i_clr(clr),
                .i_force_off(~tx_en),
                .o_flag(flags[g])
            );
        end
    endgenerate

    wire [7:0] rd_mux =
        (i_reg_addr == ADDR_TX_STATUS) ? {4'h0, flags} :
        (i_reg_addr == ADDR_TX_IRQ_EN) ? {4'h0, irq_en_ff} :
        (i_reg_addr == ADDR_CTRL) ? ctrl_ff : 8'h00;
    wire nxt_irq = |(flags & irq_en_ff);

    always_ff @(posedge i_clk or negedge rst_sync2_ff) begin
        if (!rst_sync2_ff) begin
            ctrl_ff <= CTRL_RESET;
            irq_en_ff <= IRQ_EN_RESET;
            hold_ff <= HOLD_RESET;
            hold_full_ff <= 1'b0;
            shifted_ff <= 1'b0;
            rdata_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else if (i_ce) begin
            if (wr_ctrl) ctrl_ff <= i_reg_wdata;
            if (wr_en) irq_en_ff <= i_reg_wdata[3:0];
            if (wr_hold) hold_ff <= i_reg_wdata;
            // a write in the load cycle refills the register
            if (wr_hold) hold_full_ff <= 1'b1;
            else if (take || !tx_en) hold_full_ff <= 1'b0;
            if (!tx_en) shifted_ff <= 1'b0;
            else if (i_shift_sample && hold_full_ff) shifted_ff <= 1'b1;
            if (i_reg_rd) rdata_ff <= rd_mux;
            irq_ff <= nxt_irq;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_tx_data = hold_ff;
    assign o_tx_enable = ctrl_ff[CTRL_TX_EN_BIT];
    assign o_rx_enable = ctrl_ff[CTRL_RX_EN_BIT];
    assign o_irq = irq_ff;

    // assertions
    sequence s_read_stat;
        i_ce && rd_stat && !set_vec[ST_UNFL] && !set_vec[ST_OVFL];
    endsequence

    // read with no competing underflow, overflow or done event
    sequence s_quiet_read;
        i_ce && rd_stat && !set_vec[ST_UNFL] && !set_vec[ST_OVFL]
            && !set_vec[ST_DONE];
    endsequence

    // event cycle, then a cycle that neither clears nor disables
    sequence s_ovfl_event;
        i_ce && set_vec[ST_OVFL];
    endsequence

    sequence s_done_event;
        i_ce && set_vec[ST_DONE];
    endsequence

    sequence s_keep;
        i_ce && !rd_stat && tx_en;
    endsequence

    chk_unfl_sets: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && set_vec[ST_UNFL] |=> flags[ST_UNFL])
        else $error("underflow not set");
    chk_unfl_first: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        !shifted_ff |=> !$rose(flags[ST_UNFL]))
        else $error("underflow before first bit");
    chk_read_clear: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        s_read_stat ##1 1 |-> !flags[ST_OVFL])
        else $error("status read did not clear");
    chk_ovfl_sets: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && tx_en && wr_hold && hold_full_ff && !take
        |=> flags[ST_OVFL])
        else $error("overflow not set");
    chk_done_sets: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && set_vec[ST_DONE] |=> flags[ST_DONE])
        else $error("done not set");
    chk_done_first: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        !shifted_ff |=> !$rose(flags[ST_DONE]))
        else $error("done before first bit");
    chk_empty_sets: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && take && !wr_hold |=> flags[ST_EMPTY] && !hold_full_ff)
        else $error("empty not set on load");
    chk_empty_clr: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && wr_hold && !take |=> !flags[ST_EMPTY] && hold_full_ff)
        else $error("empty not cleared by write");
    chk_tx_off: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && !tx_en |=> flags == 4'h0)
        else $error("status nonzero while disabled");
    chk_irq_out: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && |(flags & irq_en_ff) |=> o_irq)
        else $error("irq missing");
    chk_irq_drop: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && !(|(flags & irq_en_ff)) |=> !o_irq)
        else $error("irq without enabled flag");
    chk_read_clr_all: assert property (@(posedge i_clk)
        disable iff (!rst_sync2_ff)
        s_quiet_read |=> !flags[ST_UNFL] && !flags[ST_DONE])
        else $error("underflow or done not cleared by read");
    chk_stat_upper: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && rd_stat |=> o_reg_rdata[7:4] == 4'h0)
        else $error("reserved status bits nonzero");
    chk_stat_value: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && rd_stat |=> o_reg_rdata == {4'h0, $past(flags)})
        else $error("status read data wrong");
    chk_ovfl_sticky: assert property (@(posedge i_clk)
        disable iff (!rst_sync2_ff)
        s_ovfl_event ##1 s_keep |=> flags[ST_OVFL])
        else $error("overflow lost without read");
    chk_done_sticky: assert property (@(posedge i_clk)
        disable iff (!rst_sync2_ff)
        s_done_event ##1 s_keep |=> flags[ST_DONE])
        else $error("done lost without read");
    chk_empty_idle: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        i_ce && tx_en && !take && !wr_hold
        |=> flags[ST_EMPTY] == $past(flags[ST_EMPTY]))
        else $error("empty changed without cause");
    chk_ce_freeze: assert property (@(posedge i_clk) disable iff (!rst_sync2_ff)
        !i_ce |=> $stable(flags) && $stable(irq_en_ff))
        else $error("state moved while clock enable low");
endmodule : txirq_status

/* verif/txirq_shifter_model.sv */
// txirq_shifter_model: transmit shifter strobes for the status block.
// assumes the bench sets i_op at the falling edge, one op per cycle.
`timescale 1ns/1ps
module txirq_shifter_model (
    // command from bench
    input wire logic [1:0] i_op,
    // strobes to status block
    output logic o_load,
    output logic o_sample,
    output logic o_end
);
    assign o_load = (i_op == 2'h1);
    assign o_sample = (i_op == 2'h2);
    assign o_end = (i_op == 2'h3);
endmodule : txirq_shifter_model

/* verif/txirq_status_bench.sv */
// txirq_status_bench: random and corner tests of the transmit status block.
// assumes the package and the shifter model are compiled first.
`timescale 1ns/1ps
module txirq_status_bench;
    import txirq_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_ce = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [ADDR_W-1:0] i_reg_addr = '0;
    logic [DATA_W-1:0] i_reg_wdata = '0;
    logic [1:0] op = 2'h0;
    logic [7:0] o_reg_rdata, o_tx_data;
    logic sh_load, sh_sample, sh_end, o_tx_enable, o_rx_enable, o_irq;
    logic full = 1'b0;
    logic sent = 1'b0;
    logic [3:0] flg = 4'h0;
    logic [3:0] ien = 4'h0;
    logic [7:0] hold = 8'h00;
    int failures = 0;
    int num_checks = 0;
    int r;
    always #10 i_clk = ~i_clk;
    txirq_shifter_model txirq_shifter_model_i (.i_op(op), .o_load(sh_load),
        .o_sample(sh_sample), .o_end(sh_end));
    txirq_status txirq_status_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_shift_load(sh_load),
        .i_shift_sample(sh_sample), .i_shift_byte_end(sh_end),
        .o_tx_data(o_tx_data), .o_tx_enable(o_tx_enable),
        .o_rx_enable(o_rx_enable), .o_irq(o_irq));
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        i_reg_wr = w;
        i_reg_rd = ~w;
        i_reg_addr = a;
        i_reg_wdata = d;
        cyc(1);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("rdata", e, o_reg_rdata);
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        if (a == ADDR_TX_HOLD) begin
            flg[ST_OVFL] |= full;
            flg[ST_EMPTY] = 1'b0;
            full = 1'b1;
            hold = d;
        end
        if (a == ADDR_TX_IRQ_EN) ien = d[3:0];
    endtask : wr
    task automatic sh(input logic [1:0] o);
        op = o;
        cyc(1);
        op = 2'h0;
        if (o == 2'h1 && full) begin
            full = 1'b0;
            flg[ST_EMPTY] = 1'b1;
        end
        if (o == 2'h2) begin
            flg[ST_UNFL] |= sent & ~full;
            sent |= full;
        end
        if (o == 2'h3) flg[ST_DONE] |= sent & ~full;
    endtask : sh
    task automatic rd_status();
        cyc(2);
        chk("irq", {7'h00, |(flg & ien)}, {7'h00, o_irq});
        chk("tx_data", hold, o_tx_data);
        rd(ADDR_TX_STATUS, {4'h0, flg});
        flg[3:1] = 3'h0;
    endtask : rd_status
    task automatic report_and_stop();
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        void'($urandom(22802));
        cyc(10);
        i_resetn = 1'b1;
        cyc(3);
        wr(ADDR_CTRL, 8'h80);
        sh(2'h2);
        sh(2'h3);
        rd_status();
        for (int i = 0; i < 400; i++) begin
            r = $urandom % 7;
            if (r < 3) sh(2'(r + 1));
            else if (r == 3) wr(ADDR_TX_HOLD, 8'($urandom));
            else if (r == 4) rd_status();
            else if (r == 5) wr(ADDR_TX_IRQ_EN, 8'($urandom % 16));
            else wr(ADDR_TX_STATUS, 8'hFF);
        end
        rd(ADDR_TX_IRQ_EN, {4'h0, ien});
        i_ce = 1'b0;
        bus(1'b1, ADDR_TX_IRQ_EN, {4'h0, ~ien});
        i_ce = 1'b1;
        rd(ADDR_TX_IRQ_EN, {4'h0, ien});
        rd(6'h3F, 8'h00);
        wr(ADDR_TX_HOLD, 8'h5A);
        wr(ADDR_TX_HOLD, 8'hA5);
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CTRL, 8'h40);
        chk("tx_rx_en", 8'h01, {6'h00, o_tx_enable, o_rx_enable});
        rd(ADDR_TX_STATUS, 8'h00);
        report_and_stop();
    end
endmodule : txirq_status_bench
